// >>> rtl/clk_ctl_pkg.sv
// constants, state types and reset values of the clock synthesizer control
// assumes a 100 MHz control clock and a free-running synthesizer clock
// Contract
// (RULE_01) host reads by start then read address d3 hex; device acknowledges
// (RULE_02) read-back sends byte count, then configuration bytes 0 to 6
// (RULE_03) host acknowledges every read byte and ends with a stop
// (RULE_04) read-back returns the configuration latches in block-read format
// (RULE_05) serial bit rate at most 100 kbit/s, standard mode only
// (RULE_06) every serial data unit is an 8-bit byte
// (RULE_07) block writes only, ascending byte order, may end after any byte
// (RULE_08) command code and byte count are acknowledged but discarded
// (RULE_09) write bytes load successive latches until a stop arrives
// (RULE_10) all configuration registers take defaults at power-on
// (RULE_11) processor halt is synchronized; low disables processor clocks
// (RULE_12) host holds processor halt high at least 100 processor clocks
// (RULE_13) processor clocks stop low and restart with a full high phase
// (RULE_14) processor clock on and off latency below 4 processor clocks
// (RULE_15) other clocks, memory included, run on during processor halt
// (RULE_16) memory halt synchronized; memory clocks stop low, restart full
// (RULE_17) bus halt gates bus clocks 0:4 only; free bus clock runs
// (RULE_18) host holds bus halt high at least 10 bus clocks
// (RULE_19) gated bus clocks stop low and restart with full high phase
// (RULE_20) gated bus clocks restart within one edge, stop within one cycle
// (RULE_21) straps sampled at power-up into a 5-bit latch, high reads 1
// (RULE_22) after power-on reset shared pins become driven clock outputs
// (RULE_23) host writes by start then write address d2 hex; device acks
// (RULE_24) each halt input passes a two-stage synchronizer before use
package clk_ctl_pkg;

  localparam logic [7:0]  WR_ADDR     = 8'hd2;
  localparam logic [7:0]  RD_ADDR     = 8'hd3;
  localparam int          CFG_BYTES   = 7;
  localparam logic [7:0]  BYTE_COUNT  = 8'h07;
  localparam logic [7:0]  PAD_BYTE    = 8'hff;
  localparam logic [3:0]  FIRST_DATA  = 4'h2;
  localparam logic [3:0]  IDX_MAX     = 4'hf;
  localparam logic [2:0]  LAST_BIT    = 3'h7;
  localparam int          STRAP_BITS  = 5;
  localparam logic [2:0]  STRAP_LAST  = 3'h3;
  localparam logic [55:0] CFG_DEFAULT = 56'h00_0000_0000_0000;

  // synchronizer slots in the synthesizer clock domain
  localparam int SY_PROC  = 0;
  localparam int SY_MEM   = 1;
  localparam int SY_BUS   = 2;
  localparam int SY_STRAP = 3;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_ADDR  = 3'b001,
    S_RX    = 3'b010,
    S_ACK   = 3'b011,
    S_TX    = 3'b100,
    S_TXACK = 3'b101
  } ser_state_t;

  typedef struct packed {
    ser_state_t                 st;
    logic [2:0]                 bit_cnt;
    logic [7:0]                 shift;
    logic [3:0]                 idx;
    logic                       rd;
    logic                       ack_on;
    logic                       ack_ok;
    logic                       sda_oe;
    logic [1:0]                 scl_s;
    logic [1:0]                 sda_s;
    logic                       scl_d;
    logic                       sda_d;
    logic [CFG_BYTES-1:0][7:0]  cfg;
    logic [STRAP_BITS-1:0]      strap_s0;
    logic [STRAP_BITS-1:0]      strap_s1;
    logic [STRAP_BITS-1:0]      strap;
    logic [2:0]                 strap_cnt;
    logic                       strap_done;
  } ctl_state_t;

  typedef struct packed {
    logic [1:0] ph;
    logic [3:0] sy0;
    logic [3:0] sy1;
    logic       proc_o;
    logic       mem_o;
    logic       bus_o;
    logic       free_o;
    logic       shr_o;
    logic       shr_oe;
  } gate_state_t;

  localparam ctl_state_t CTL_RST = '{st: S_IDLE, cfg: CFG_DEFAULT,
                                     default: '0};
  // the phase starts one short of wrap so that the first free bus clock
  // high phase after reset has full width
  localparam gate_state_t GATE_RST = '{ph: 2'h3, default: '0};

endpackage

// >>> rtl/clock_synth_control_serial.sv
// serial configuration slave, strap latch and glitch-free clock gating
// assumes scl, sda, halts and straps are asynchronous to both clocks
`timescale 1ns/100ps
module clock_synth_control_serial
  import clk_ctl_pkg::*;
#(
  parameter int PROC_N = 3,
  parameter int MEM_N  = 13,
  parameter int BUS_N  = 5
) (
  // control clock and reset
  input  wire logic                      mclk,
  input  wire logic                      rst_b,
  // synthesizer clock that the outputs are derived from
  input  wire logic                      synth_clk,
  // serial bus, open drain
  input  wire logic                      scl_in,
  input  wire logic                      sda_in,
  output logic                           sda_out,
  output logic                           sda_oe,
  // halt inputs, active low
  input  wire logic                      proc_halt_b,
  input  wire logic                      mem_halt_b,
  input  wire logic                      bus_halt_b,
  // gated clock outputs and the free-running bus clock
  output logic [PROC_N-1:0]              proc_clock_out,
  output logic [MEM_N-1:0]               mem_clock_out,
  output logic [BUS_N-1:0]               bus_clock_out,
  output logic                           bus_free_clock_out,
  // shared strap pins
  input  wire logic [STRAP_BITS-1:0]     shared_in,
  output logic [STRAP_BITS-1:0]          shared_out,
  output logic [STRAP_BITS-1:0]          shared_oe,
  // latched configuration
  output logic [CFG_BYTES*8-1:0]         cfg_bytes,
  output logic [STRAP_BITS-1:0]          strap_cfg,
  output logic                           strap_valid
);

  ctl_state_t  s_reg, s_next;
  gate_state_t g_reg, g_next;

  logic       scl, sda, rise, fall, start, stop;
  logic [7:0] rx_byte;

  assign scl     = s_reg.scl_s[1];
  assign sda     = s_reg.sda_s[1];
  assign rise    = scl & ~s_reg.scl_d;
  assign fall    = ~scl & s_reg.scl_d;
  assign start   = scl & s_reg.scl_d & s_reg.sda_d & ~sda;
  assign stop    = scl & s_reg.scl_d & ~s_reg.sda_d & sda;
  assign rx_byte = {s_reg.shift[6:0], sda};

  function automatic logic [7:0] tx_byte(input ctl_state_t s);
    if (s.idx == 4'h0)
      tx_byte = BYTE_COUNT;
    else if (s.idx <= 4'(CFG_BYTES))
      tx_byte = s.cfg[s.idx - 4'h1];
    else
      tx_byte = PAD_BYTE;
  endfunction

  // ---------------- control clock domain ----------------
  always_comb begin
    logic [7:0] txb;
    txb = tx_byte(s_reg);
    s_next = s_reg;
    // 100 MHz oversampling is ample for a standard-mode bus only
    s_next.scl_s = {s_reg.scl_s[0], scl_in}; // RULE_05
    s_next.sda_s = {s_reg.sda_s[0], sda_in};
    s_next.scl_d = scl;
    s_next.sda_d = sda;
    s_next.strap_s0 = shared_in;
    s_next.strap_s1 = s_reg.strap_s0;
    // pins are still inputs until strap_done has crossed over
    if (!s_reg.strap_done) begin
      s_next.strap     = s_reg.strap_s1; // RULE_21
      s_next.strap_cnt = s_reg.strap_cnt + 3'h1;
      if (s_reg.strap_cnt == STRAP_LAST)
        s_next.strap_done = 1'b1;
    end
    if (stop) begin
      s_next.st     = S_IDLE; // RULE_09
      s_next.sda_oe = 1'b0;
    end else if (start) begin
      s_next.st      = S_ADDR;
      s_next.bit_cnt = 3'h0;
      s_next.idx     = 4'h0;
      s_next.sda_oe  = 1'b0;
    end else begin
      case (s_reg.st)
        S_ADDR, S_RX: begin
          if (rise) begin
            s_next.shift   = rx_byte;
            s_next.bit_cnt = s_reg.bit_cnt + 3'h1;
            if (s_reg.bit_cnt == LAST_BIT) begin // RULE_06
              s_next.st     = S_ACK;
              s_next.ack_on = 1'b0;
              if (s_reg.st == S_ADDR) begin
                if (rx_byte == WR_ADDR)
                  s_next.rd = 1'b0; // RULE_23
                else if (rx_byte == RD_ADDR)
                  s_next.rd = 1'b1; // RULE_01
                else
                  s_next.st = S_IDLE;
              end else begin
                // command code and count land nowhere
                if (s_reg.idx >= FIRST_DATA &&
                    s_reg.idx < FIRST_DATA + 4'(CFG_BYTES))
                  s_next.cfg[s_reg.idx - FIRST_DATA] = rx_byte; // RULE_08
                if (s_reg.idx != IDX_MAX)
                  s_next.idx = s_reg.idx + 4'h1; // RULE_07
              end
            end
          end
        end
        S_ACK: begin
          if (fall) begin
            if (!s_reg.ack_on) begin
              s_next.ack_on = 1'b1;
              s_next.sda_oe = 1'b1;
            end else begin
              s_next.ack_on  = 1'b0;
              s_next.bit_cnt = 3'h0;
              if (s_reg.rd) begin
                s_next.st     = S_TX; // RULE_02
                s_next.shift  = txb;
                s_next.sda_oe = ~txb[7];
              end else begin
                s_next.st     = S_RX;
                s_next.sda_oe = 1'b0;
              end
            end
          end
        end
        S_TX: begin
          if (fall) begin
            if (s_reg.bit_cnt == LAST_BIT) begin
              s_next.sda_oe = 1'b0;
              s_next.ack_ok = 1'b0;
              s_next.st     = S_TXACK;
              if (s_reg.idx != IDX_MAX)
                s_next.idx = s_reg.idx + 4'h1;
            end else begin
              s_next.bit_cnt = s_reg.bit_cnt + 3'h1;
              s_next.shift   = {s_reg.shift[6:0], 1'b0};
              s_next.sda_oe  = ~s_reg.shift[6];
            end
          end
        end
        S_TXACK: begin
          if (rise) begin
            s_next.ack_ok = ~sda; // RULE_03
          end else if (fall) begin
            if (s_reg.ack_ok) begin
              s_next.st      = S_TX; // RULE_04
              s_next.bit_cnt = 3'h0;
              s_next.shift   = txb;
              s_next.sda_oe  = ~txb[7];
            end else begin
              s_next.st = S_IDLE;
            end
          end
        end
        default: begin
          s_next.st = S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b)
      s_reg <= CTL_RST; // RULE_10
    else
      s_reg <= s_next;
  end

  // ---------------- synthesizer clock domain ----------------
  always_comb begin
    logic [1:0] ph;
    ph = g_reg.ph + 2'h1;
    g_next = g_reg;
    g_next.ph  = ph;
    g_next.sy0 = {s_reg.strap_done, bus_halt_b, mem_halt_b, proc_halt_b};
    g_next.sy1 = g_reg.sy0; // RULE_24
    // one-cycle high phases cannot be cut short by a late enable
    g_next.proc_o = g_reg.sy1[SY_PROC] & ~ph[0]; // RULE_11 RULE_13 RULE_14
    g_next.mem_o  = g_reg.sy1[SY_MEM] & ~ph[0]; // RULE_15 RULE_16
    // the bus enable is only looked at as a high phase begins
    if (ph[1])
      g_next.bus_o = 1'b0; // RULE_19
    else if (!ph[0])
      g_next.bus_o = g_reg.sy1[SY_BUS]; // RULE_20
    g_next.free_o = ~ph[1]; // RULE_17
    g_next.shr_o  = ~ph[0];
    g_next.shr_oe = g_reg.sy1[SY_STRAP]; // RULE_22
  end

  always_ff @(posedge synth_clk or negedge rst_b) begin
    if (!rst_b)
      g_reg <= GATE_RST;
    else
      g_reg <= g_next;
  end

  assign sda_out            = 1'b0;
  assign sda_oe             = s_reg.sda_oe;
  assign cfg_bytes          = s_reg.cfg;
  assign strap_cfg          = s_reg.strap;
  assign strap_valid        = s_reg.strap_done;
  assign proc_clock_out     = {PROC_N{g_reg.proc_o}};
  assign mem_clock_out      = {MEM_N{g_reg.mem_o}};
  assign bus_clock_out      = {BUS_N{g_reg.bus_o}};
  assign bus_free_clock_out = g_reg.free_o;
  assign shared_out         = {STRAP_BITS{g_reg.shr_o}};
  assign shared_oe          = {STRAP_BITS{g_reg.shr_oe}};

  // ---------------- checks ----------------
  chk_addr_match: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_01
    (s_reg.st == S_ADDR && rise && s_reg.bit_cnt == LAST_BIT)
    |=> ((s_reg.st == S_ACK) ==
         ($past(rx_byte) == WR_ADDR || $past(rx_byte) == RD_ADDR)))
    else $error("address acknowledge does not match address byte");

  chk_tx_count: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_02
    (s_reg.st == S_TX && $past(s_reg.st) == S_ACK)
    |-> (s_reg.shift == BYTE_COUNT && s_reg.idx == 4'h0))
    else $error("read-back does not open with the byte count");

  chk_write_store: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_09
    (s_reg.st == S_RX && rise && s_reg.bit_cnt == LAST_BIT &&
     s_reg.idx == FIRST_DATA && !start && !stop)
    |=> (s_reg.cfg[0] == $past(rx_byte)))
    else $error("first write data byte not stored in byte 0");

  chk_stop_release: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_03
    stop |=> (!sda_oe && s_reg.st == S_IDLE))
    else $error("data line still held after stop");

  chk_strap_hold: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_21
    strap_valid |=> ($stable(strap_cfg) && strap_valid))
    else $error("strap latch changed after power-on sampling");

  chk_proc_off: assert property (@(posedge synth_clk) disable iff (!rst_b) // RULE_14
    (!proc_halt_b) [*5] |-> !g_reg.proc_o)
    else $error("processor clock not stopped in time");

  chk_proc_on: assert property (@(posedge synth_clk) disable iff (!rst_b) // RULE_14
    proc_halt_b [*7] |-> (g_reg.proc_o || $past(g_reg.proc_o)))
    else $error("processor clock not restarted in time");

  chk_mem_run: assert property (@(posedge synth_clk) disable iff (!rst_b) // RULE_15
    mem_halt_b [*7] |-> (g_reg.mem_o || $past(g_reg.mem_o)))
    else $error("memory clock disturbed while enabled");

  chk_mem_off: assert property (@(posedge synth_clk) disable iff (!rst_b) // RULE_16
    (!mem_halt_b) [*5] |-> !g_reg.mem_o)
    else $error("memory clock not stopped low");

  chk_bus_off: assert property (@(posedge synth_clk) disable iff (!rst_b) // RULE_20
    (!bus_halt_b) [*5] |-> !g_reg.bus_o)
    else $error("gated bus clock not stopped within one cycle");

  chk_bus_pulse: assert property (@(posedge synth_clk) disable iff (!rst_b) // RULE_19
    $rose(g_reg.bus_o) |-> (g_reg.free_o ##1 (g_reg.bus_o ##1 !g_reg.bus_o)))
    else $error("gated bus clock high phase cut short");

  chk_free_bus: assert property (@(posedge synth_clk) disable iff (!rst_b) // RULE_17
    $rose(g_reg.free_o) |=> (g_reg.free_o ##1 !g_reg.free_o ##1
                             !g_reg.free_o ##1 g_reg.free_o))
    else $error("free-running bus clock disturbed");

  chk_bus_on: assert property (@(posedge synth_clk) disable iff (!rst_b) // RULE_20
    bus_halt_b [*8] |-> (g_reg.bus_o || $past(g_reg.bus_o) ||
                         $past(g_reg.bus_o, 2)))
    else $error("gated bus clock not restarted in time");

  chk_strap_input: assert property (@(posedge mclk) disable iff (!rst_b) // RULE_21
    !strap_valid |-> (shared_oe == '0))
    else $error("shared pins driven before straps were latched");

  chk_pin_drive: assert property (@(posedge synth_clk) disable iff (!rst_b) // RULE_22
    g_reg.shr_oe |-> strap_valid)
    else $error("shared pins driven without a latched strap");

  cov_read_byte: cover property (@(posedge mclk) disable iff (!rst_b)
    s_reg.st == S_TXACK ##[1:1000] (s_reg.st == S_TX && s_reg.idx == 4'h7));
  cov_write_last: cover property (@(posedge mclk) disable iff (!rst_b)
    s_reg.st == S_RX && s_reg.idx == FIRST_DATA + 4'(CFG_BYTES));
  cov_proc_halt: cover property (@(posedge synth_clk) disable iff (!rst_b)
    (!proc_halt_b) [*8] ##1 proc_halt_b);
  cov_bus_halt: cover property (@(posedge synth_clk) disable iff (!rst_b)
    $fell(g_reg.bus_o) ##1 (!bus_halt_b) [*8]);
  cov_strap_drive: cover property (@(posedge synth_clk) disable iff (!rst_b)
    $rose(g_reg.shr_oe));

endmodule

// >>> tb/serial_host_model.sv
// host side model: serial master on scl/sda and the three halt pins
// assumes the device's open-drain data pin and a pull-up on both lines
`timescale 1ns/100ps
module serial_host_model (
  // bit timer
  input  wire logic       mclk,
  // device side of the data line
  input  wire logic       sda_out,
  input  wire logic       sda_oe,
  // resolved bus levels
  output logic            scl,
  output wire logic       sda,
  // halts, active low: proc, mem, bus
  output logic [2:0]      halt_b
);
  // phases twice as fast as standard mode to keep the run short;
  // the slave only needs about 6 control clocks a phase
  localparam int HALF = 250;
  logic host_low;

  // pull-up: a released line reads high
  assign sda = ~host_low & (sda_oe ? sda_out : 1'b1);

  initial begin
    scl      = 1'b1;
    host_low = 1'b0;
    halt_b   = 3'h7;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic start();
    host_low = 1'b0;
    scl      = 1'b1;
    tick(HALF);
    host_low = 1'b1;
    tick(HALF);
  endtask

  task automatic stop();
    scl = 1'b0;
    tick(4);
    host_low = 1'b1;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    host_low = 1'b0;
    tick(HALF);
  endtask

  // data only moves while scl is low, well after its fall
  task automatic xfer_bit(input logic b_out, output logic b_in);
    scl = 1'b0;
    tick(4);
    host_low = ~b_out;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    b_in = sda;
  endtask

  task automatic xfer_byte(input logic [7:0] d_out, input logic ack_bit,
                           output logic [7:0] d_in, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) xfer_bit(d_out[i], d_in[i]);
    xfer_bit(ack_bit, a);
    ack = ~a;
  endtask

  // a new halt waits out the minimum high time of the last release
  task automatic set_halt(input int k, input logic v);
    if (!v) tick(1000);
    halt_b[k] = v;
  endtask
endmodule

// >>> tb/tb_top.sv
// self-checking bench: straps, serial write and read-back, halts
// assumes the serial host model drives scl, sda and the halt pins
`timescale 1ns/100ps
module tb_top
  import clk_ctl_pkg::*;
;
  localparam logic [4:0] STRAP_VAL = 5'h15;
  logic        mclk, synth_clk, rst_b, scl, sda, sda_out, sda_oe, ack;
  logic        free_clk, strap_valid;
  logic [2:0]  halt_b, proc_clk;
  logic [12:0] mem_clk;
  logic [4:0]  bus_clk, shared_in, shared_out, shared_oe, strap_cfg;
  logic [55:0] cfg_bytes, exp_cfg;
  logic [63:0] exp_rd;
  logic [7:0]  rx;
  logic [7:0]  wr_data [3] = '{8'h81, 8'h5a, 8'hc3};
  int          num_errors, check_count, pc, mc, bc, fc;

  // strap resistors set the level whenever the device is not driving
  assign shared_in = (shared_oe & shared_out) | (~shared_oe & STRAP_VAL);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    synth_clk = 1'b0;
    #7;
    forever #24 synth_clk = ~synth_clk;
  end

  clock_synth_control_serial u_dut (
    .mclk(mclk), .rst_b(rst_b), .synth_clk(synth_clk),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .proc_halt_b(halt_b[0]), .mem_halt_b(halt_b[1]),
    .bus_halt_b(halt_b[2]), .proc_clock_out(proc_clk),
    .mem_clock_out(mem_clk), .bus_clock_out(bus_clk),
    .bus_free_clock_out(free_clk), .shared_in(shared_in),
    .shared_out(shared_out), .shared_oe(shared_oe),
    .cfg_bytes(cfg_bytes), .strap_cfg(strap_cfg),
    .strap_valid(strap_valid));

  serial_host_model u_host (
    .mclk(mclk), .sda_out(sda_out), .sda_oe(sda_oe), .scl(scl),
    .sda(sda), .halt_b(halt_b));

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    if (num_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic send(input logic [7:0] b);
    u_host.xfer_byte(b, 1'b1, rx, ack);
    check(64'(ack), 64'h1);
  endtask

  // counts control cycles in which each clock group is high
  task automatic watch(input int n);
    pc = 0; mc = 0; bc = 0; fc = 0;
    repeat (n) begin
      @(negedge mclk);
      pc += int'(|proc_clk);
      mc += int'(|mem_clk);
      bc += int'(|bus_clk);
      fc += int'(free_clk);
    end
  endtask

  // 40 control cycles sit just above 4 processor clocks of latency
  task automatic halt_case(input int k, input logic [3:0] run);
    u_host.set_halt(k, 1'b0);
    repeat (40) @(negedge mclk);
    watch(100);
    check(64'({pc > 0, mc > 0, bc > 0, fc > 0}), 64'(run));
    u_host.set_halt(k, 1'b1);
    repeat (40) @(negedge mclk);
    watch(100);
    check(64'({pc > 0, mc > 0, bc > 0, fc > 0}), 64'hf);
  endtask

  initial begin
    rst_b = 1'b0;
    num_errors = 0;
    check_count = 0;
    repeat (10) @(negedge mclk);
    check(64'(cfg_bytes), 64'(CFG_DEFAULT));
    check(64'({proc_clk, mem_clk, bus_clk, shared_oe}), 64'h0);
    rst_b = 1'b1;
    for (int i = 0; i < 50 && strap_valid !== 1'b1; i++) @(negedge mclk);
    if (strap_valid !== 1'b1) begin
      num_errors++;
      close_out();
    end
    check(64'(strap_cfg), 64'(STRAP_VAL));
    repeat (20) @(negedge mclk);
    check(64'({shared_oe, strap_cfg}), 64'({5'h1f, STRAP_VAL}));
    @(negedge synth_clk);
    rx[0] = shared_out[0];
    @(negedge synth_clk);
    check(64'(rx[0] ^ shared_out[0]), 64'h1);
    u_host.start();
    send(WR_ADDR);
    send(8'h5a);
    send(8'h03);
    foreach (wr_data[k]) send(wr_data[k]);
    u_host.stop();
    exp_cfg = CFG_DEFAULT;
    foreach (wr_data[k]) exp_cfg[8*k +: 8] = wr_data[k];
    check(64'(cfg_bytes), 64'(exp_cfg));
    exp_rd = {exp_cfg, BYTE_COUNT};
    u_host.start();
    send(RD_ADDR);
    for (int k = 0; k < 8; k++) begin
      u_host.xfer_byte(8'hff, 1'b0, rx, ack);
      check(64'(rx), 64'(exp_rd[8*k +: 8]));
    end
    u_host.stop();
    u_host.start();
    u_host.xfer_byte(8'ha4, 1'b1, rx, ack);
    check(64'(ack), 64'h0);
    u_host.stop();
    halt_case(0, 4'h7);
    halt_case(1, 4'hb);
    halt_case(2, 4'hd);
    close_out();
  end

  initial begin
    repeat (95000) @(posedge mclk);
    num_errors++;
    close_out();
  end
endmodule
